// file: logic/wdr_top.sv
// Purpose: Watchdog reset timer with AXI4-Lite registers.
// Assumes: Commands arrive as protected words written to the command
//          register; hw_reset_i is the synchronous reset pin level.
// Notes:   Interrupt status is sticky; a set beats a clear in one cycle.
// Function
// - Any reset enables the timer, clears the count, selects divide by two.
// - Rate select high divides the clock by 128, low by two.
// - Disable is honoured only before the first end-of-init or service.
// - An enabled timer counts only in the run state; bus wait and reset sequence hold it at zero.
// - Overflow starts an internal reset and drives reset indication low.
// - Overflow reset sets the overflow flag; hardware or software reset, end-of-init or service clear it.
// - Overflow waits for or aborts a running bus cycle by its ready.
// - Boot select low at hardware reset end disables the timer in boot mode.
// - Service clears the low byte and loads the high byte from reload.
// - A malformed service is not executed and raises a protection fault.
// - Period is prescale times (65536 minus reload times 256) clocks.
// - End-of-init clears control bits one to four.
// - Counter is two chained bytes, top preset and bottom cleared.
// - Control holds reload, rate and flag; the count reads only.
`timescale 1ns/1ps
module wdr_top (
  input  wire logic                          clk_i,
  input  wire logic                          rstn_i,
  input  wire logic [wdr_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [wdr_pkg::DATA_W-1:0]    s_axi_wdata_i,
  input  wire logic [3:0]                    s_axi_wstrb_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  output logic [1:0]                         s_axi_bresp_o,
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  input  wire logic [wdr_pkg::ADDR_W-1:0]    s_axi_araddr_i,
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  output logic [wdr_pkg::DATA_W-1:0]         s_axi_rdata_o,
  output logic [1:0]                         s_axi_rresp_o,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  input  wire logic                          hw_reset_i,
  input  wire logic                          boot_select_pin_i,
  input  wire wdr_pkg::wdr_bus_cycle_t       bus_cycle_i,
  output logic                               reset_indication_out_no,
  output logic                               internal_reset_o,
  output logic                               bus_abort_o,
  output logic                               prot_fault_o,
  output logic                               serial_boot_mode_o,
  output logic                               irq_o
);

  // ---------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------
  function automatic wdr_pkg::wdr_sel_t reg_sel(
    input logic [wdr_pkg::ADDR_W-1:0] addr
  );
    logic [wdr_pkg::ADDR_W-1:0] a;
    a = {addr[wdr_pkg::ADDR_W-1:2], 2'h0};
    if (a == wdr_pkg::OFF_CTRL) begin
      reg_sel = wdr_pkg::SEL_CTRL;
    end else if (a == wdr_pkg::OFF_COUNT) begin
      reg_sel = wdr_pkg::SEL_COUNT;
    end else if (a == wdr_pkg::OFF_CMD) begin
      reg_sel = wdr_pkg::SEL_CMD;
    end else if (a == wdr_pkg::OFF_STAT) begin
      reg_sel = wdr_pkg::SEL_STAT;
    end else if (a == wdr_pkg::OFF_EN) begin
      reg_sel = wdr_pkg::SEL_EN;
    end else if (a == wdr_pkg::OFF_CLR) begin
      reg_sel = wdr_pkg::SEL_CLR;
    end else begin
      reg_sel = wdr_pkg::SEL_NONE;
    end
  endfunction

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic                          awready_q, awready_d;
  logic                          wready_q, wready_d;
  logic                          aw_got_q, aw_got_d;
  logic                          w_got_q, w_got_d;
  logic                          bvalid_q, bvalid_d;
  logic [1:0]                    bresp_q;
  logic [wdr_pkg::ADDR_W-1:0]    aw_addr_q;
  logic [wdr_pkg::DATA_W-1:0]    w_data_q;
  logic [3:0]                    w_strb_q;
  logic                          arready_q, arready_d;
  logic                          rvalid_q, rvalid_d;
  logic [wdr_pkg::DATA_W-1:0]    rdata_q;
  logic [1:0]                    rresp_q;
  wdr_pkg::wdr_ctrl_t            ctrl_q, ctrl_d;
  wdr_pkg::wdr_state_t           st_q, st_d;
  logic [wdr_pkg::SEQ_W-1:0]     seq_q;
  logic                          disabled_q, dis_ok_q, boot_q, hw_seen_q;
  logic [wdr_pkg::IRQ_W-1:0]     stat_q, stat_d, en_q, en_d;
  logic                          irq_q, reset_indication_out_n_q, int_rst_q;
  logic                          abort_q, fault_q;
  logic [15:0]                   count;
  logic                          tick, ovf;

  localparam logic [wdr_pkg::SEQ_W-1:0] SEQ_LAST =
    wdr_pkg::SEQ_W'(wdr_pkg::RESET_SEQ_CYCLES - 1);

  // ---------------------------------------------------------------------
  // AXI4-Lite write and read channels
  // ---------------------------------------------------------------------
  wire aw_take = s_axi_awvalid_i & awready_q;
  wire w_take  = s_axi_wvalid_i & wready_q;
  wire wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  wire ar_take = s_axi_arvalid_i & arready_q;

  assign aw_got_d  = (aw_got_q | aw_take) & ~wr_fire;
  assign w_got_d   = (w_got_q | w_take) & ~wr_fire;
  assign bvalid_d  = wr_fire | (bvalid_q & ~s_axi_bready_i);
  assign awready_d = ~aw_got_d & ~bvalid_d;
  assign wready_d  = ~w_got_d & ~bvalid_d;
  assign rvalid_d  = ar_take | (rvalid_q & ~s_axi_rready_i);
  assign arready_d = ~rvalid_d;

  wire wdr_pkg::wdr_sel_t wr_sel = reg_sel(aw_addr_q);
  wire wdr_pkg::wdr_sel_t rd_sel = reg_sel(s_axi_araddr_i);

  wire [1:0] wr_resp = (wr_sel == wdr_pkg::SEL_NONE) ?
                       wdr_pkg::RESP_SLVERR : wdr_pkg::RESP_OKAY;
  wire [1:0] rd_resp = (rd_sel == wdr_pkg::SEL_NONE) ?
                       wdr_pkg::RESP_SLVERR : wdr_pkg::RESP_OKAY;

  // Write-only and command registers read as zero.
  wire [wdr_pkg::DATA_W-1:0] rd_word =
    (rd_sel == wdr_pkg::SEL_CTRL)  ? {16'h0000, ctrl_q} :
    (rd_sel == wdr_pkg::SEL_COUNT) ? {16'h0000, count} :
    (rd_sel == wdr_pkg::SEL_STAT)  ?
      {{(wdr_pkg::DATA_W-wdr_pkg::IRQ_W){1'b0}}, stat_q} :
    (rd_sel == wdr_pkg::SEL_EN)    ?
      {{(wdr_pkg::DATA_W-wdr_pkg::IRQ_W){1'b0}}, en_q} :
    32'h0000_0000;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= 4'h0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= 2'h0;
    end else begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      bvalid_q  <= bvalid_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      if (aw_take) aw_addr_q <= s_axi_awaddr_i;
      if (w_take) begin
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (wr_fire) bresp_q <= wr_resp;
      if (ar_take) begin
        rdata_q <= rd_word;
        rresp_q <= rd_resp;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Protected command decode
  // ---------------------------------------------------------------------
  // A full-word write with a complemented upper half is the only legal
  // form, so a stray store is very unlikely to service the timer.
  wire [15:0] op      = w_data_q[15:0];
  wire        key_ok  = (w_data_q[31:16] == ~op) & (&w_strb_q);
  wire        cmd_wr  = wr_fire & (wr_sel == wdr_pkg::SEL_CMD);
  wire        in_run  = (st_q == wdr_pkg::ST_RUN) & ~hw_reset_i;
  wire        op_srv  = key_ok & (op == wdr_pkg::OP_SERVICE);
  wire        op_dis  = key_ok & (op == wdr_pkg::OP_DISABLE);
  wire        op_eoi  = key_ok & (op == wdr_pkg::OP_EOI);
  wire        op_swr  = key_ok & (op == wdr_pkg::OP_SWRESET);
  wire        op_ok   = op_srv | op_dis | op_eoi | op_swr;
  wire        fault   = cmd_wr & ~op_ok;
  wire        svc     = cmd_wr & op_srv & in_run;
  wire        eoi     = cmd_wr & op_eoi & in_run;
  wire        sw_rst  = cmd_wr & op_swr & in_run;
  wire        dis_req = cmd_wr & op_dis & in_run;

  // ---------------------------------------------------------------------
  // Reset sequencing
  // ---------------------------------------------------------------------
  wire seq_done  = (st_q == wdr_pkg::ST_SEQ) & (seq_q == SEQ_LAST);
  wire dog_init  = hw_reset_i | sw_rst | seq_done;
  wire hw_end    = hw_seen_q & ~hw_reset_i;
  wire abort_now = bus_cycle_i.active & bus_cycle_i.uses_ready &
                   bus_cycle_i.waits_done & bus_cycle_i.ready_n;
  // A cycle that ignores ready, or saw it low, is allowed to run out.
  wire bus_free  = ~bus_cycle_i.active | abort_now;
  wire run       = in_run & ~sw_rst & ~disabled_q & ~boot_q;
  wire ovf_ev    = ovf & run & ~svc;
  wire cnt_zero  = dog_init | (st_q != wdr_pkg::ST_RUN);

  always_comb begin
    st_d = st_q;
    case (st_q)
      wdr_pkg::ST_RUN: begin
        if (ovf_ev) st_d = wdr_pkg::ST_BUS_WAIT;
      end
      wdr_pkg::ST_BUS_WAIT: begin
        if (bus_free) st_d = wdr_pkg::ST_SEQ;
      end
      wdr_pkg::ST_SEQ: begin
        if (seq_done) st_d = wdr_pkg::ST_RUN;
      end
      default: st_d = wdr_pkg::ST_RUN;
    endcase
    if (hw_reset_i) st_d = wdr_pkg::ST_RUN;
  end

  // ---------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------
  wire ctrl_wr = wr_fire & (wr_sel == wdr_pkg::SEL_CTRL);

  always_comb begin
    ctrl_d = ctrl_q;
    if (hw_reset_i) begin
      ctrl_d = wdr_pkg::CTRL_HW_RESET;
    end else if (seq_done) begin
      ctrl_d = wdr_pkg::CTRL_DOG_RESET;
    end else if (sw_rst) begin
      ctrl_d = wdr_pkg::CTRL_SW_RESET;
    end else begin
      if (ctrl_wr && w_strb_q[0]) begin
        ctrl_d.input_rate_select = w_data_q[0];
      end
      if (ctrl_wr && w_strb_q[1]) begin
        ctrl_d.reload_high_byte = w_data_q[15:8];
      end
      if (eoi) ctrl_d = ctrl_d & ~wdr_pkg::CTRL_EOI_MASK;
      if (svc) ctrl_d.dog_overflow_flag = 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------
  wire [wdr_pkg::IRQ_W-1:0] ev;
  wire [wdr_pkg::IRQ_W-1:0] clr_bits;

  assign ev[wdr_pkg::IRQ_OVF]   = ovf_ev;
  assign ev[wdr_pkg::IRQ_FAULT] = fault;
  assign clr_bits = (wr_fire && wr_sel == wdr_pkg::SEL_CLR) ?
                    w_data_q[wdr_pkg::IRQ_W-1:0] : '0;
  assign stat_d   = (stat_q & ~clr_bits) | ev;
  assign en_d     = (wr_fire && wr_sel == wdr_pkg::SEL_EN) ?
                    w_data_q[wdr_pkg::IRQ_W-1:0] : en_q;

  // ---------------------------------------------------------------------
  // Timer datapath
  // ---------------------------------------------------------------------
  wdr_prescaler #(
    .W       (wdr_pkg::PRESC_W)
  ) u_presc (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .clear_i (cnt_zero | svc),
    .run_i   (run),
    .slow_i  (ctrl_q.input_rate_select),
    .tick_o  (tick)
  );

  wdr_counter #(
    .NB       (2)
  ) u_count (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .zero_i   (cnt_zero),
    .load_i   (svc),
    .reload_i (ctrl_q.reload_high_byte),
    .tick_i   (tick),
    .count_o  (count),
    .ovf_o    (ovf)
  );

  // ---------------------------------------------------------------------
  // Watchdog state registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_q     <= wdr_pkg::CTRL_HW_RESET;
      st_q       <= wdr_pkg::ST_RUN;
      seq_q      <= '0;
      disabled_q <= 1'b0;
      dis_ok_q   <= 1'b1;
      boot_q     <= 1'b0;
      hw_seen_q  <= 1'b1;
      stat_q     <= '0;
      en_q       <= '0;
    end else begin
      ctrl_q    <= ctrl_d;
      st_q      <= st_d;
      seq_q     <= (st_q == wdr_pkg::ST_SEQ) ?
                   wdr_pkg::SEQ_W'(seq_q + 1'b1) : '0;
      hw_seen_q <= hw_reset_i;
      stat_q    <= stat_d;
      en_q      <= en_d;
      if (dog_init) begin
        disabled_q <= 1'b0;
        dis_ok_q   <= 1'b1;
      end else begin
        if (dis_req && dis_ok_q) disabled_q <= 1'b1;
        if (svc || eoi) dis_ok_q <= 1'b0;
      end
      // Boot mode is left only by a software reset or a new hardware reset.
      if (hw_end) begin
        boot_q <= ~boot_select_pin_i;
      end else if (sw_rst || hw_reset_i) begin
        boot_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_q      <= 1'b0;
      reset_indication_out_n_q <= 1'b1;
      int_rst_q  <= 1'b0;
      abort_q    <= 1'b0;
      fault_q    <= 1'b0;
    end else begin
      irq_q      <= |(stat_d & en_d);
      reset_indication_out_n_q <= (st_d != wdr_pkg::ST_SEQ);
      int_rst_q  <= (st_d == wdr_pkg::ST_SEQ);
      abort_q    <= (st_q == wdr_pkg::ST_BUS_WAIT) & abort_now &
                    ~hw_reset_i;
      fault_q    <= fault;
    end
  end

  assign s_axi_awready_o         = awready_q;
  assign s_axi_wready_o          = wready_q;
  assign s_axi_bvalid_o          = bvalid_q;
  assign s_axi_bresp_o           = bresp_q;
  assign s_axi_arready_o         = arready_q;
  assign s_axi_rvalid_o          = rvalid_q;
  assign s_axi_rdata_o           = rdata_q;
  assign s_axi_rresp_o           = rresp_q;
  assign reset_indication_out_no = reset_indication_out_n_q;
  assign internal_reset_o        = int_rst_q;
  assign bus_abort_o             = abort_q;
  assign prot_fault_o            = fault_q;
  assign serial_boot_mode_o      = boot_q;
  assign irq_o                   = irq_q;

endmodule

// file: logic/wdr_pkg.sv
// Purpose: Shared constants and types for the watchdog reset timer.
// Assumes: 32-bit AXI4-Lite register access, one clock domain.
// Notes:   Command opcodes are arbitrary values chosen for this block.
package wdr_pkg;

  // ---------------------------------------------------------------------
  // Bus and register map
  // ---------------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CMD   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STAT  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_EN    = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CLR   = 8'h14;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------
  // Control register values
  // ---------------------------------------------------------------------
  localparam logic [15:0] CTRL_HW_RESET  = 16'h001C;
  localparam logic [15:0] CTRL_SW_RESET  = 16'h0004;
  localparam logic [15:0] CTRL_DOG_RESET = 16'h0006;
  localparam logic [15:0] CTRL_EOI_MASK  = 16'h001E;

  // ---------------------------------------------------------------------
  // Protected commands: upper half must be the complement of the lower.
  // ---------------------------------------------------------------------
  localparam logic [15:0] OP_SERVICE = 16'h00A1;
  localparam logic [15:0] OP_DISABLE = 16'h00A2;
  localparam logic [15:0] OP_EOI     = 16'h00A3;
  localparam logic [15:0] OP_SWRESET = 16'h00A4;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned PRESC_W          = 7;
  localparam int unsigned RESET_SEQ_CYCLES = 516;
  localparam int unsigned SEQ_W            = 10;
  localparam logic [7:0]  BYTE_MAX         = 8'hFF;

  // ---------------------------------------------------------------------
  // Interrupt status bits
  // ---------------------------------------------------------------------
  localparam int unsigned IRQ_W     = 2;
  localparam int unsigned IRQ_OVF   = 0;
  localparam int unsigned IRQ_FAULT = 1;

  typedef struct packed {
    logic active;
    logic uses_ready;
    logic ready_n;
    logic waits_done;
  } wdr_bus_cycle_t;

  typedef struct packed {
    logic [7:0] reload_high_byte;
    logic [2:0] rsvd;
    logic       long_hw;
    logic       short_hw;
    logic       sw;
    logic       dog_overflow_flag;
    logic       input_rate_select;
  } wdr_ctrl_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_BUS_WAIT,
    ST_SEQ
  } wdr_state_t;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_COUNT,
    SEL_CMD,
    SEL_STAT,
    SEL_EN,
    SEL_CLR,
    SEL_NONE
  } wdr_sel_t;

endpackage

// file: logic/wdr_prescaler.sv
// Purpose: Input clock divider for the watchdog count, by 2 or by 128.
// Assumes: clear_i has priority over run_i.
// Notes:   tick_o is combinational and lasts one cycle.
`timescale 1ns/1ps
module wdr_prescaler #(
  parameter int unsigned W = 7
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic clear_i,
  input  wire logic run_i,
  input  wire logic slow_i,
  output logic      tick_o
);

  logic [W-1:0] cnt_q;
  wire          at_end;

  // Fast rate ends on every second cycle, slow rate after 2**W cycles.
  assign at_end = slow_i ? (&cnt_q) : cnt_q[0];
  assign tick_o = run_i & ~clear_i & at_end;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else if (clear_i) begin
      cnt_q <= '0;
    end else if (run_i) begin
      cnt_q <= at_end ? '0 : W'(cnt_q + 1'b1);
    end
  end

endmodule

// file: logic/wdr_counter.sv
// Purpose: 16-bit watchdog count built from chained 8-bit stages.
// Assumes: zero_i beats load_i, which beats tick_i.
// Notes:   ovf_o is combinational and lasts one cycle.
`timescale 1ns/1ps
module wdr_counter #(
  parameter int unsigned NB = 2
) (
  input  wire logic          clk_i,
  input  wire logic          rstn_i,
  input  wire logic          zero_i,
  input  wire logic          load_i,
  input  wire logic [7:0]    reload_i,
  input  wire logic          tick_i,
  output logic [8*NB-1:0]    count_o,
  output logic               ovf_o
);

  logic [NB:0] carry;

  assign carry[0] = tick_i;
  assign ovf_o    = carry[NB];

  generate
    for (genvar i = 0; i < NB; i++) begin : g_stage
      logic [7:0] byte_q;
      wire  [7:0] load_val;
      // Service presets the top stage and clears the lower ones.
      if (i == NB - 1) begin : g_top
        assign load_val = reload_i;
      end else begin : g_low
        assign load_val = 8'h00;
      end
      assign carry[i+1]          = carry[i] & (byte_q == wdr_pkg::BYTE_MAX);
      assign count_o[8*i +: 8]   = byte_q;
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          byte_q <= 8'h00;
        end else if (zero_i) begin
          byte_q <= 8'h00;
        end else if (load_i) begin
          byte_q <= load_val;
        end else if (carry[i]) begin
          byte_q <= 8'(byte_q + 1'b1);
        end
      end
    end
  endgenerate

endmodule

// file: test/wdr_top_monitor.sv
// Purpose: Port-level assertions for the watchdog reset timer.
// Assumes: One clock; rstn_i is the only asynchronous reset.
// Notes:   Bound to wdr_top below the module.
`timescale 1ns/1ps
module wdr_monitor (
  input wire logic                    clk_i,
  input wire logic                    rstn_i,
  input wire logic                    s_axi_awvalid_i,
  input wire logic                    s_axi_awready_o,
  input wire logic                    s_axi_wvalid_i,
  input wire logic                    s_axi_wready_o,
  input wire logic                    s_axi_bvalid_o,
  input wire logic                    s_axi_arvalid_i,
  input wire logic                    s_axi_arready_o,
  input wire logic                    s_axi_rvalid_o,
  input wire wdr_pkg::wdr_bus_cycle_t bus_cycle_i,
  input wire logic                    reset_indication_out_no,
  input wire logic                    internal_reset_o,
  input wire logic                    bus_abort_o,
  input wire logic                    prot_fault_o,
  input wire logic                    serial_boot_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // -------------------------------------------------------------------
  // Length of the low phase and other port checks
  // -------------------------------------------------------------------
  // A counter, because a repetition of 516 would choke the tools.
  logic [9:0] low_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) low_q <= 10'h000;
    else low_q <= reset_indication_out_no ? 10'h000 : low_q + 10'h001;
  end
  property p_pair; internal_reset_o != reset_indication_out_no; endproperty
  a_pair: assert property (p_pair) else $error("reset outputs disagree");
  property p_len; $rose(reset_indication_out_no) |-> low_q == 10'h204;
  endproperty
  a_len: assert property (p_len) else $error("sequence length off");
  property p_cause; $fell(reset_indication_out_no) |-> $past(!bus_cycle_i.active
    || (bus_cycle_i.uses_ready && bus_cycle_i.waits_done && bus_cycle_i.ready_n));
  endproperty
  a_cause: assert property (p_cause) else $error("bus cycle cut");
  property p_boot; $fell(reset_indication_out_no) |-> !serial_boot_mode_o;
  endproperty
  a_boot: assert property (p_boot) else $error("overflow in boot mode");
  property p_abort; bus_abort_o |-> ##[0:1] !reset_indication_out_no;
  endproperty
  a_abort: assert property (p_abort) else $error("abort without reset");
  property p_fault; prot_fault_o |=> !prot_fault_o; endproperty
  a_fault: assert property (p_fault) else $error("fault pulse too long");
  property p_wresp; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |=> ##1 s_axi_bvalid_o; endproperty
  a_wresp: assert property (p_wresp) else $error("write response late");
  property p_rresp; s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read response late");
endmodule
bind wdr_top wdr_monitor u_wdr_monitor (.*);

// file: test/wdr_top_test.sv
// Purpose: Self-checking bench for the watchdog reset timer.
// Assumes: Register map and command words of wdr_pkg.
// Notes:   Overflow timing is checked with a few cycles of slack.
`timescale 1ns/1ps
module wdr_top_test;
  logic                    clk_i = 1'b0, rstn_i = 1'b0, hw_reset_i = 1'b0;
  logic                    boot_select_pin_i = 1'b1, abort_seen = 1'b0;
  logic                    s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic                    s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic                    s_axi_rready_i = 1'b0;
  logic [7:0]              s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0]             s_axi_wdata_i = 32'h0, rdat, rb, rnd;
  logic [3:0]              s_axi_wstrb_i = 4'hF;
  logic [1:0]              s_axi_bresp_o, s_axi_rresp_o, rsp;
  wdr_pkg::wdr_bus_cycle_t bus_cycle_i = 4'h0;
  logic                    s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic                    s_axi_arready_o, s_axi_rvalid_o, irq_o;
  logic                    reset_indication_out_no, internal_reset_o;
  logic                    bus_abort_o, prot_fault_o, serial_boot_mode_o;
  logic [31:0]             s_axi_rdata_o;
  int                      error_cnt = 0, n_tests = 0, seed = 32'h015D37FF;
  wdr_top u_wdr_top (.*);
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (bus_abort_o === 1'b1) abort_seen <= 1'b1;
  // -------------------------------------------------------------------
  // Bus tasks and checks
  // -------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // The leading edge keeps a new request off the edge that ended the last.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad = 1'b0, wd = 1'b0;
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_i);
      if (!ad && s_axi_awready_o === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (!wd && s_axi_wready_o === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
    s_axi_bready_i <= 1'b0;
    rsp = s_axi_bresp_o;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
    s_axi_rready_i <= 1'b0;
    rdat = s_axi_rdata_o;
    rsp = s_axi_rresp_o;
  endtask
  task automatic cmd(input logic [15:0] op);
    wr(wdr_pkg::OFF_CMD, {~op, op});
  endtask
  task automatic moves(input logic [31:0] e);
    rd(wdr_pkg::OFF_COUNT);
    rb = rdat;
    repeat (300) @(posedge clk_i);
    rd(wdr_pkg::OFF_COUNT);
    chk(32'(rdat != rb), e);
  endtask
  task automatic ovf(input int rate, input int rel);
    int n = 0, e;
    e = (1 << (1 + 6 * rate)) * (65536 - rel * 256);
    while (reset_indication_out_no === 1'b1 && n < e + 8) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n > e - 8 && n < e + 8), 32'h1);
    while (reset_indication_out_no !== 1'b1) @(posedge clk_i);
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(wdr_pkg::OFF_CTRL);
    chk(rdat, 32'h1C);
    rd(8'h20);
    chk(32'(rsp), 32'(wdr_pkg::RESP_SLVERR));
    wr(8'h20, 32'h0);
    chk(32'(rsp), 32'(wdr_pkg::RESP_SLVERR));
    cmd(wdr_pkg::OP_DISABLE);
    moves(32'h0);
    cmd(wdr_pkg::OP_SWRESET);
    rd(wdr_pkg::OFF_CTRL);
    chk(rdat, 32'h4);
    wr(wdr_pkg::OFF_EN, 32'h3);
    wr(wdr_pkg::OFF_CMD, {16'h0, wdr_pkg::OP_SERVICE});
    rd(wdr_pkg::OFF_STAT);
    chk(rdat, 32'h2);
    chk(32'(irq_o), 32'h1);
    wr(wdr_pkg::OFF_CLR, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 32'h0);
    rnd = $random(seed);
    wr(wdr_pkg::OFF_CTRL, rnd);
    cmd(wdr_pkg::OP_EOI);
    rd(wdr_pkg::OFF_CTRL);
    chk(rdat, rnd & 32'hFF01);
    cmd(wdr_pkg::OP_DISABLE);
    moves(32'h1);
    bus_cycle_i <= 4'hF;
    wr(wdr_pkg::OFF_CTRL, 32'hFF00);
    cmd(wdr_pkg::OP_SERVICE);
    ovf(0, 255);
    chk(32'(abort_seen), 32'h1);
    rd(wdr_pkg::OFF_CTRL);
    chk(rdat, 32'h6);
    bus_cycle_i <= 4'h8;
    wr(wdr_pkg::OFF_CTRL, 32'hFF01);
    cmd(wdr_pkg::OP_SERVICE);
    rd(wdr_pkg::OFF_CTRL);
    chk(rdat, 32'hFF05);
    repeat (32800) @(posedge clk_i);
    chk(32'(reset_indication_out_no), 32'h1);
    bus_cycle_i <= 4'h0;
    repeat (4) @(posedge clk_i);
    chk(32'(reset_indication_out_no), 32'h0);
    while (reset_indication_out_no !== 1'b1) @(posedge clk_i);
    hw_reset_i <= 1'b1;
    boot_select_pin_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    hw_reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    boot_select_pin_i <= 1'b1;
    chk(32'(serial_boot_mode_o), 32'h1);
    moves(32'h0);
    complete_run();
  end
endmodule
